// [hw/cimc_pkg.sv]
`default_nettype none
package cimc_pkg;
	localparam logic [7:0] CIMC_FLAG0_OFS = 8'h00;
	localparam logic [7:0] CIMC_FLAG1_OFS = 8'h01;
	localparam logic [7:0] CIMC_FLAG2_OFS = 8'h02;
	localparam logic [7:0] CIMC_MASK0_OFS = 8'h03;
	localparam logic [7:0] CIMC_MASK1_OFS = 8'h04;
	localparam logic [7:0] CIMC_MASK2_OFS = 8'h05;
	localparam logic [7:0] CIMC_STAT_OFS = 8'h06;
	localparam logic [7:0] CIMC_CTRL_OFS = 8'h07;
	localparam logic [7:0] CIMC_MASK0_RST = 8'h03;
	localparam logic [7:0] CIMC_MASK1_RST = 8'hB8;
	localparam logic [7:0] CIMC_MASK2_RST = 8'hFF;
	localparam logic [7:0] CIMC_CTRL_RST = 8'h42;
	localparam logic [7:0] CIMC_CTRL_WMASK = 8'h4F;
	localparam int CIMC_CTRL_CMP_BIT = 6;
	localparam int CIMC_CTRL_SWRST_BIT = 3;
	localparam int CIMC_CTRL_SUSP_BIT = 2;
	localparam int CIMC_CTRL_CHG_BIT = 1;
	localparam int CIMC_CTRL_BOOST_BIT = 0;
	localparam logic [7:0] CIMC_CMP_EV0 = 8'h04;
	localparam logic [7:0] CIMC_CMP_EV1 = 8'h20;
	localparam logic [7:0] CIMC_CMP_EV2 = 8'h0D;
	localparam logic [7:0] CIMC_MASK2_RSVD = 8'hF0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cimc_req_t;

	typedef struct packed {
		logic rail_overload_flag;
		logic discharge_limit_flag;
		logic thermal_shutdown_flag;
		logic battery_present_flag;
		logic suspend_active;
	} cimc_live_t;

	typedef struct packed {
		logic comparator_enable;
		logic input_switch_suspend;
		logic charger_enable;
		logic boost_output_enable;
	} cimc_ctl_t;
endpackage
`default_nettype wire

// [hw/cimc_regbank.sv]
`default_nettype none
// Functional notes
// - Mask bit zero passes its event to the interrupt; one suppresses it.
// - First mask gates input and thermal events, bit 7 down to 0.
// - First mask resets to 0x03, thermal events masked.
// - Second mask gates timer, battery, boost, restart, done, top-off events.
// - Second mask resets to 0xB8.
// - Third mask resets 0xFF; low nibble gates rail events; software writes ones above.
// - Status is read-only; bits 7:5 reserved, read zero.
// - Status bit 4 shows rail overload with valid input.
// - Status bit 3 shows discharge current limit.
// - Status bit 2 shows thermal shutdown.
// - Status bit 1 shows battery attached.
// - Status bit 0 shows suspend enabled.
// - Control bit 6 enables event comparators; resets to one.
// - Control bit 3 pulses a charge-parameter reset and self-clears.
// - Control bit 2 suspends the input switch; resets to zero.
// - Control bits 1 and 0 enable charger and boost; register resets 0x42.
// - Three clear-on-read flag registers at 00 to 02, one bit per mask bit.
// - Comparator events without valid input flag only when comparators enabled.
module cimc_regbank (
	input wire logic clk_in, // 100 MHz clock.
	input wire logic rst_b_in, // Asynchronous reset, low at rail undervoltage.
	input wire cimc_pkg::cimc_req_t req_in, // Register access from the serial front end.
	input wire logic [23:0] event_in, // Event pulses, flag register 2..0 bit order.
	input wire logic input_valid_in, // Valid input supply present, same clock.
	input wire cimc_pkg::cimc_live_t live_in, // Live conditions, same clock.
	output logic [7:0] rdata_out, // Read data, valid the cycle after rd.
	output logic irq_out, // Interrupt, registered: high the cycle after an unmasked flag is set, low the cycle after none is.
	output cimc_pkg::cimc_ctl_t ctl_out, // Control bits to the power stage.
	output logic param_reset_out // One-cycle charge-parameter reset pulse.
);
	import cimc_pkg::*;

	logic [7:0] mask_r [3];
	logic [7:0] flag_r [3];
	logic [7:0] ctrl_r;
	logic [7:0] stat_nxt;
	logic [7:0] rd_nxt;
	logic [23:0] ev_gated;
	logic [23:0] cmp_sel;
	logic wr_ctrl;

	assign cmp_sel = {CIMC_CMP_EV2, CIMC_CMP_EV1, CIMC_CMP_EV0};
	// Comparator-sourced events are dropped only when no valid input is present and the comparators are disabled.
	assign ev_gated = event_in &
		~(cmp_sel & {24{~input_valid_in & ~ctrl_r[CIMC_CTRL_CMP_BIT]}});
	assign stat_nxt = {3'h0, live_in};
	assign wr_ctrl = req_in.wr && (req_in.addr == CIMC_CTRL_OFS);

	// Flags set wins over the clear-on-read of the same cycle.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_reg
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					flag_r[g] <= 8'h00;
				end else begin
					flag_r[g] <= ((req_in.rd && req_in.addr == CIMC_FLAG0_OFS + 8'(g)) ?
						8'h00 : flag_r[g]) | ev_gated[g*8 +: 8];
				end
			end
			always_ff @(posedge clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					mask_r[g] <= (g == 0) ? CIMC_MASK0_RST :
						(g == 1) ? CIMC_MASK1_RST : CIMC_MASK2_RST;
				end else if (req_in.wr && req_in.addr == CIMC_MASK0_OFS + 8'(g)) begin
					mask_r[g] <= req_in.wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_r <= CIMC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= req_in.wdata & CIMC_CTRL_WMASK & ~(8'h01 << CIMC_CTRL_SWRST_BIT);
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			param_reset_out <= 1'b0;
		end else begin
			param_reset_out <= wr_ctrl && req_in.wdata[CIMC_CTRL_SWRST_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctl_out <= '{1'b1, 1'b0, 1'b1, 1'b0};
		end else begin
			ctl_out.comparator_enable <= ctrl_r[CIMC_CTRL_CMP_BIT];
			ctl_out.input_switch_suspend <= ctrl_r[CIMC_CTRL_SUSP_BIT];
			ctl_out.charger_enable <= ctrl_r[CIMC_CTRL_CHG_BIT];
			ctl_out.boost_output_enable <= ctrl_r[CIMC_CTRL_BOOST_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |((flag_r[0] & ~mask_r[0]) | (flag_r[1] & ~mask_r[1]) |
				(flag_r[2] & ~mask_r[2]));
		end
	end

	always_comb begin
		case (req_in.addr)
			CIMC_FLAG0_OFS: rd_nxt = flag_r[0];
			CIMC_FLAG1_OFS: rd_nxt = flag_r[1];
			CIMC_FLAG2_OFS: rd_nxt = flag_r[2];
			CIMC_MASK0_OFS: rd_nxt = mask_r[0];
			CIMC_MASK1_OFS: rd_nxt = mask_r[1];
			CIMC_MASK2_OFS: rd_nxt = mask_r[2];
			CIMC_STAT_OFS: rd_nxt = stat_nxt;
			CIMC_CTRL_OFS: rd_nxt = ctrl_r;
			default: rd_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			rdata_out <= rd_nxt;
		end
	end

	irq_unmasked_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		((flag_r[0] & ~mask_r[0]) != 8'h00) |=> irq_out)
		else $error("unmasked flag did not raise interrupt");
	irq_masked_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(((flag_r[0] & ~mask_r[0]) | (flag_r[1] & ~mask_r[1]) |
		(flag_r[2] & ~mask_r[2])) == 8'h00) |=> !irq_out)
		else $error("interrupt without unmasked flag");
	flag_latch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		ev_gated[0] |=> flag_r[0][0])
		else $error("event lost in flag register");
	cmp_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!input_valid_in && !ctrl_r[CIMC_CTRL_CMP_BIT] && !flag_r[0][2] &&
		!(req_in.rd && req_in.addr == CIMC_FLAG0_OFS)) |=> !flag_r[0][2])
		else $error("comparator event flagged while disabled");
	swrst_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(wr_ctrl && req_in.wdata[CIMC_CTRL_SWRST_BIT]) |=>
		(param_reset_out && !ctrl_r[CIMC_CTRL_SWRST_BIT]) ##1
		(!param_reset_out || $past(wr_ctrl && req_in.wdata[CIMC_CTRL_SWRST_BIT])))
		else $error("software reset not a self-clearing pulse");

	// The pulse never appears without a write of one to the reset bit.
	prst_only_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!(wr_ctrl && req_in.wdata[CIMC_CTRL_SWRST_BIT]) |=> !param_reset_out)
		else $error("parameter reset pulse without request");

	// The stored reset bit always reads back as zero.
	swrst_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!ctrl_r[CIMC_CTRL_SWRST_BIT])
		else $error("software reset bit did not self-clear");

	// Reserved control bits never hold a one.
	ctrl_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ctrl_r & ~CIMC_CTRL_WMASK) == 8'h00)
		else $error("reserved control bit set");

	// Boost enable follows the written value two cycles later.
	boost_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_ctrl |=> ##1 (ctl_out.boost_output_enable == $past(req_in.wdata[0], 2)))
		else $error("boost enable not following write");

	// Comparator enable follows the written value two cycles later.
	cmp_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_ctrl |=> ##1 (ctl_out.comparator_enable == $past(req_in.wdata[6], 2)))
		else $error("comparator enable not following write");

	// The second and third flag registers also reach the interrupt.
	irq_flag1_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		((flag_r[1] & ~mask_r[1]) != 8'h00) |=> irq_out)
		else $error("unmasked charge flag did not raise interrupt");

	irq_flag2_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		((flag_r[2] & ~mask_r[2]) != 8'h00) |=> irq_out)
		else $error("unmasked rail flag did not raise interrupt");

	// A read with no new event empties the flag register.
	flag0_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr == CIMC_FLAG0_OFS && ev_gated[7:0] == 8'h00) |=>
		(flag_r[0] == 8'h00))
		else $error("first flag register not cleared by read");

	flag1_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr == CIMC_FLAG1_OFS && ev_gated[15:8] == 8'h00) |=>
		(flag_r[1] == 8'h00))
		else $error("second flag register not cleared by read");

	flag2_clear_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr == CIMC_FLAG2_OFS && ev_gated[23:16] == 8'h00) |=>
		(flag_r[2] == 8'h00))
		else $error("third flag register not cleared by read");

	// Without a read, a set flag stays set.
	flag_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!(req_in.rd && req_in.addr == CIMC_FLAG1_OFS) |=>
		((flag_r[1] & $past(flag_r[1])) == $past(flag_r[1])))
		else $error("flag lost without a read");

	// A masked event still latches its flag.
	masked_latch_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(ev_gated[8] && mask_r[1][0]) |=> flag_r[1][0])
		else $error("masked event did not latch");

	// Comparator events stay silent while disabled without a valid input.
	cmp_weak_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!input_valid_in && !ctrl_r[CIMC_CTRL_CMP_BIT] && !flag_r[1][5] &&
		!(req_in.rd && req_in.addr == CIMC_FLAG1_OFS)) |=> !flag_r[1][5])
		else $error("weak battery event flagged while disabled");

	cmp_rail_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(!input_valid_in && !ctrl_r[CIMC_CTRL_CMP_BIT] &&
		(flag_r[2] & CIMC_CMP_EV2) == 8'h00) |=> ((flag_r[2] & CIMC_CMP_EV2) == 8'h00))
		else $error("rail event flagged while disabled");

	// With a valid input the comparator events are always reported.
	cmp_override_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(input_valid_in && event_in[2]) |=> flag_r[0][2])
		else $error("comparator event lost with valid input");

	// The other two masks store what is written.
	mask0_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.wr && req_in.addr == CIMC_MASK0_OFS) |=> (mask_r[0] == $past(req_in.wdata)))
		else $error("first mask write not stored");

	mask2_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.wr && req_in.addr == CIMC_MASK2_OFS) |=> (mask_r[2] == $past(req_in.wdata)))
		else $error("third mask write not stored");

	// A mask changes only when it is written.
	mask_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!(req_in.wr && req_in.addr == CIMC_MASK0_OFS) |=> $stable(mask_r[0]))
		else $error("first mask changed without a write");

	// Reserved status bits read as zero.
	stat_rsvd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr == CIMC_STAT_OFS) |=> (rdata_out[7:5] == 3'h0))
		else $error("reserved status bits not zero");

	// Read data stands until the next read.
	rdata_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!req_in.rd |=> $stable(rdata_out))
		else $error("read data changed without a read");

	// Unmapped offsets read as zero.
	unmapped_rd_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr > CIMC_CTRL_OFS) |=> (rdata_out == 8'h00))
		else $error("unmapped read not zero");
	status_live_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.rd && req_in.addr == CIMC_STAT_OFS) |=>
		(rdata_out == {3'h0, $past(live_in)}))
		else $error("status read mismatch");
	ctrl_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_ctrl |=> ##1 (ctl_out.charger_enable == $past(req_in.wdata[1], 2)))
		else $error("charger enable not following write");
	susp_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_ctrl |=> ##1 (ctl_out.input_switch_suspend == $past(req_in.wdata[2], 2)))
		else $error("suspend not following write");
	mask_write_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(req_in.wr && req_in.addr == CIMC_MASK1_OFS) |=> (mask_r[1] == $past(req_in.wdata)))
		else $error("mask write not stored");
endmodule // cimc_regbank
`default_nettype wire

// [dv/cimc_host.sv]
`default_nettype none
module cimc_host (
	input wire logic clk_in, // Bus clock.
	input wire logic [7:0] rdata_in, // Read data from the bank.
	output cimc_pkg::cimc_req_t req_out // Request to the bank.
);
	timeunit 1ns;
	timeprecision 1ns;
	import cimc_pkg::*;
	initial req_out = '0;
	// One-cycle strobe; read data is taken once the answering edge has landed.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk_in);
		req_out <= '{w, !w, a, (a == CIMC_MASK2_OFS) ? (d | CIMC_MASK2_RSVD) : d};
		@(posedge clk_in);
		req_out <= '0;
		#1 q = rdata_in;
	endtask
endmodule // cimc_host
`default_nettype wire

// [dv/charger_irq_mask_status_ctrl_tb.sv]
`default_nettype none
module charger_irq_mask_status_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cimc_pkg::*;
	logic clk = 0, rst_b = 0, iv = 0, irq, prst;
	logic [23:0] ev = '0, e;
	cimc_live_t live = '0;
	cimc_req_t req;
	cimc_ctl_t ctl;
	logic [7:0] rdata, q, c, d, lv, xi;
	logic [7:0] m [3];
	logic [7:0] f [3];
	int n_fail = 0, num_checks = 0, cyc = 0;
	cimc_regbank u_dut (.clk_in(clk), .rst_b_in(rst_b), .req_in(req), .event_in(ev),
		.input_valid_in(iv), .live_in(live), .rdata_out(rdata), .irq_out(irq),
		.ctl_out(ctl), .param_reset_out(prst));
	cimc_host u_host (.clk_in(clk), .rdata_in(rdata), .req_out(req));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] s, input logic [7:0] x);
		num_checks++;
		if (s !== x) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		u_host.xfer(1'b0, a, 8'h00, q);
		chk(q, x);
	endtask
	task automatic give_verdict();
		$display("checks=%0d fails=%0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		void'($urandom(11315));
		f = '{8'h00, 8'h00, 8'h00};
		repeat (16) @(posedge clk);
		chk({4'h0, ctl}, 8'h0A);
		rst_b <= 1'b1;
		rd(8'h03, 8'h03);
		rd(8'h04, 8'hB8);
		rd(8'h05, 8'hFF);
		rd(8'h07, 8'h42);
		rd(8'h1F, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 24; i++) begin
			for (int k = 0; k < 3; k++) begin
				m[k] = 8'($urandom);
				u_host.xfer(1'b1, 8'h03 + 8'(k), m[k], q);
				if (k == 2)
					m[k] |= 8'hF0;
				rd(8'h03 + 8'(k), m[k]);
			end
			d = 8'($urandom);
			u_host.xfer(1'b1, 8'h07, d, q);
			chk({7'h0, prst}, {7'h0, d[3]});
			c = d & 8'h47;
			rd(8'h07, c);
			chk({4'h0, ctl}, {4'h0, c[6], c[2:0]});
			lv = 8'($urandom);
			@(posedge clk);
			live <= lv[4:0];
			u_host.xfer(1'b1, 8'h06, 8'hFF, q);
			rd(8'h06, {3'b000, lv[4:0]});
			e = {4'h0, 20'($urandom)};
			@(posedge clk);
			iv <= 1'($urandom);
			ev <= e;
			@(posedge clk);
			ev <= '0;
			if (!iv && !c[6])
				e &= ~{CIMC_CMP_EV2, CIMC_CMP_EV1, CIMC_CMP_EV0};
			for (int k = 0; k < 3; k++)
				f[k] |= e[8*k +: 8];
			@(posedge clk);
			xi = {7'h0, |((f[0] & ~m[0]) | (f[1] & ~m[1]) |
				(f[2] & ~m[2]))};
			#1 chk({7'h0, irq}, xi);
			for (int k = 0; k < 3; k++) begin
				rd(8'(k), f[k]);
				f[k] = 8'h00;
			end
			@(posedge clk);
			#1 chk({7'h0, irq}, 8'h00);
		end
		$display("random test done");
		give_verdict();
	end
endmodule // charger_irq_mask_status_ctrl_tb
`default_nettype wire
